// File: rtl/idc_dispatch.sv
/*
  Dispatch stage: takes up to three decoded entries per cycle from the
  bottom of the instruction queue and sends them to the issue queues.
  Assumes the instruction queue shifts out iq_take entries each cycle,
  issue queues report free slots, and retire/release counts are honest.
*/
`timescale 1ns/1ns
`default_nettype none
`include "idc_params.svh"
module idc_dispatch #(
  parameter int CQ_DEPTH = `IDC_CQ_DEPTH,
  parameter int GPR_REN = `IDC_GPR_REN,
  parameter int VR_REN = `IDC_VR_REN,
  parameter int FPR_REN = `IDC_FPR_REN
) (
  input wire logic ref_clk, // Core clock
  input wire logic srst, // Sync reset
  input wire idc_pkg::idc_entry_t [2:0] dispatch_entries, // Entry 0 oldest
  input wire logic [2:0] giq_room, // General queue free slots
  input wire logic [2:0] viq_room, // Vector queue free slots
  input wire logic [2:0] fiq_room, // Float queue free slots
  input wire logic [1:0] cq_retire, // Completion entries retired
  input wire logic [1:0] g_release, // General renames freed
  input wire logic [1:0] v_release, // Vector renames freed
  input wire logic [1:0] f_release, // Float renames freed
  output logic [1:0] iq_take, // Entries consumed now
  output idc_pkg::idc_op_t [2:0] disp_ops, // Dispatched group
  output logic [4:0] g_free_cnt, // General renames free
  output logic [4:0] cq_used // Completion entries used
);
  // ---------------------------------------------
  // State
  // ---------------------------------------------
  idc_pkg::idc_state_t s_reg;
  idc_pkg::idc_state_t s_next;
  logic [1:0] take_c;

  assign iq_take = take_c;
  assign disp_ops = s_reg.ops;
  assign g_free_cnt = s_reg.g_free;
  assign cq_used = s_reg.cq_cnt;

  // ---------------------------------------------
  // Group formation
  // ---------------------------------------------
  always_comb
  begin
    idc_pkg::idc_entry_t e;
    idc_pkg::idc_op_t op;
    logic ok;
    logic fit;
    logic last;
    logic [4:0] n_tot;
    logic [4:0] n_g;
    logic [4:0] n_v;
    logic [4:0] n_f;
    logic [4:0] n_mem;
    logic [4:0] r_g;
    logic [4:0] r_v;
    logic [4:0] r_f;
    logic [4:0] n_cq;
    logic [4:0] need_g;
    logic [4:0] need_v;
    logic [4:0] need_f;
    logic [4:0] reg_now;
    e = '0;
    op = '0;
    ok = 1'b1;
    fit = 1'b0;
    last = 1'b0;
    n_tot = '0;
    n_g = '0;
    n_v = '0;
    n_f = '0;
    n_mem = '0;
    r_g = '0;
    r_v = '0;
    r_f = '0;
    n_cq = '0;
    need_g = '0;
    need_v = '0;
    need_f = '0;
    reg_now = '0;
    s_next = s_reg;
    take_c = 2'b00;
    for (int k = 0; k < `IDC_LANES; k++)
    begin
      e = dispatch_entries[k];
      op = '0;
      reg_now = s_reg.mop_active ? s_reg.mop_reg : e.first_reg;
      last = (reg_now == `IDC_LAST_REG);
      if (e.multi)
      begin
        // One rename per loaded word; stores target nothing
        need_g = {4'h0, ~e.mstore}; // RQ11
        need_v = '0;
        need_f = '0;
      end
      else
      begin
        need_g = {4'h0, e.g_tgt} + {4'h0, e.upd}; // RQ7
        need_v = {4'h0, e.v_tgt};
        need_f = {4'h0, e.f_tgt};
      end
      unique case (e.queue)
        idc_pkg::IDC_Q_GEN: fit = (n_g < `IDC_LIM_GIQ) && (n_g < {2'b00, giq_room});
        idc_pkg::IDC_Q_VEC: fit = (n_v < `IDC_LIM_VIQ) && (n_v < {2'b00, viq_room});
        idc_pkg::IDC_Q_FLT: fit = (n_f < `IDC_LIM_FIQ) && (n_f < {2'b00, fiq_room});
        idc_pkg::IDC_Q_BR: fit = e.br_ready;
      endcase // RQ4 RQ1
      // Split operations start only from the oldest entry
      if (e.multi && k != 0)
        fit = 1'b0; // RQ11
      if ((e.mem || e.multi) && n_mem >= `IDC_LIM_MEM)
        fit = 1'b0; // RQ5 RQ13
      if (n_tot >= `IDC_LIM_TOT)
        fit = 1'b0; // RQ3
      // Branches run from the instruction buffer, no completion entry
      if (e.queue != idc_pkg::IDC_Q_BR
          && (5'(32'(s_reg.cq_cnt) + 32'(n_cq)) >= 5'(CQ_DEPTH)))
        fit = 1'b0; // RQ9 RQ1
      if (r_g + need_g > `IDC_LIM_RG || r_v + need_v > `IDC_LIM_RV
          || r_f + need_f > `IDC_LIM_RF)
        fit = 1'b0; // RQ6
      if (r_g + need_g > s_reg.g_free || r_v + need_v > s_reg.v_free
          || r_f + need_f > s_reg.f_free)
        fit = 1'b0; // RQ8 RQ10 RQ1
      // Once one entry holds, every younger one holds too
      ok = ok && e.valid && fit; // RQ2 RQ14
      if (ok)
      begin
        op.valid = 1'b1;
        op.queue = e.queue;
        op.mem = e.mem || e.multi;
        op.mop = e.multi;
        op.ren_g = need_g[1:0];
        op.ren_v = need_v[0];
        op.ren_f = need_f[0];
        n_tot = n_tot + 5'h01;
        n_mem = n_mem + {4'h0, op.mem};
        if (e.queue != idc_pkg::IDC_Q_BR)
          n_cq = n_cq + 5'h01;
        unique case (e.queue)
          idc_pkg::IDC_Q_GEN: n_g = n_g + 5'h01;
          idc_pkg::IDC_Q_VEC: n_v = n_v + 5'h01;
          idc_pkg::IDC_Q_FLT: n_f = n_f + 5'h01;
          idc_pkg::IDC_Q_BR: n_tot = n_tot;
        endcase // RQ4
        r_g = r_g + need_g;
        r_v = r_v + need_v;
        r_f = r_f + need_f;
        if (e.multi)
        begin
          op.mreg = reg_now; // RQ12
          op.mword = s_reg.mop_active ? s_reg.mop_word : 5'h00; // RQ12
          s_next.mop_active = !last;
          s_next.mop_reg = reg_now + 5'h01;
          s_next.mop_word = op.mword + 5'h01;
          // Only the final piece frees the entry for younger ones
          ok = last; // RQ13 RQ11
          if (last)
            take_c = take_c + 2'b01;
        end
        else
          take_c = take_c + 2'b01;
      end
      s_next.ops[k] = op;
    end
    s_next.cq_cnt = s_reg.cq_cnt + n_cq - {3'b000, cq_retire}; // RQ9
    s_next.g_free = s_reg.g_free - r_g + {3'b000, g_release}; // RQ10
    s_next.v_free = s_reg.v_free - r_v + {3'b000, v_release}; // RQ10
    s_next.f_free = s_reg.f_free - r_f + {3'b000, f_release}; // RQ10
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s_reg <= '0;
      s_reg.g_free <= 5'(GPR_REN); // RQ8
      s_reg.v_free <= 5'(VR_REN);
      s_reg.f_free <= 5'(FPR_REN);
    end
    else
      s_reg <= s_next;
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  function automatic logic [4:0] cnt_q(idc_pkg::idc_op_t [2:0] o, idc_pkg::idc_queue_t q);
    cnt_q = 5'h00;
    for (int i = 0; i < 3; i++)
      cnt_q = cnt_q + {4'h0, o[i].valid && o[i].queue == q};
  endfunction

  property p_order;
    disp_ops[2].valid |-> disp_ops[1].valid && disp_ops[0].valid;
  endproperty
  a_order: assert property (p_order) else $error("group out of order"); // RQ2

  property p_queue_lim;
    cnt_q(disp_ops, idc_pkg::IDC_Q_VEC) <= `IDC_LIM_VIQ
      && cnt_q(disp_ops, idc_pkg::IDC_Q_FLT) <= `IDC_LIM_FIQ;
  endproperty
  a_queue_lim: assert property (p_queue_lim) else $error("queue limit broken"); // RQ4

  property p_one_mem;
    $onehot0({disp_ops[2].mem, disp_ops[1].mem, disp_ops[0].mem});
  endproperty
  a_one_mem: assert property (p_one_mem) else $error("two memory ops"); // RQ5

  property p_ren_g;
    {3'b000, disp_ops[0].ren_g} + {3'b000, disp_ops[1].ren_g}
      + {3'b000, disp_ops[2].ren_g} <= `IDC_LIM_RG;
  endproperty
  a_ren_g: assert property (p_ren_g) else $error("general rename limit"); // RQ6

  property p_cq_full;
    s_reg.cq_cnt == 5'(CQ_DEPTH) |=> !disp_ops[0].valid || disp_ops[0].queue == idc_pkg::IDC_Q_BR;
  endproperty
  a_cq_full: assert property (p_cq_full) else $error("dispatch into full completion queue"); // RQ9

  property p_pool_bound;
    s_reg.g_free <= 5'(GPR_REN) && s_reg.cq_cnt <= 5'(CQ_DEPTH);
  endproperty
  a_pool_bound: assert property (p_pool_bound) else $error("pool count out of range"); // RQ8

  // A reset refills the pool, which is not a release
  property p_release;
    !$past(srst) && s_reg.g_free > $past(s_reg.g_free)
      |-> s_reg.g_free - $past(s_reg.g_free) <= {3'b000, $past(g_release)};
  endproperty
  a_release: assert property (p_release) else $error("renames freed without release"); // RQ10

  property p_mop_step;
    disp_ops[0].mop && disp_ops[0].mreg != `IDC_LAST_REG |=> (disp_ops[0].mop
      |-> disp_ops[0].mreg == $past(disp_ops[0].mreg) + 5'h01
      && disp_ops[0].mword == $past(disp_ops[0].mword) + 5'h01);
  endproperty
  a_mop_step: assert property (p_mop_step) else $error("micro-op sequence broken"); // RQ12

  property p_one_mop;
    !disp_ops[1].mop && !disp_ops[2].mop;
  endproperty
  a_one_mop: assert property (p_one_mop) else $error("split op outside lane 0"); // RQ11

  property p_take;
    take_c <= 2'({1'b0, dispatch_entries[0].valid} + {1'b0, dispatch_entries[1].valid}
      + {1'b0, dispatch_entries[2].valid});
  endproperty
  a_take: assert property (p_take) else $error("took an empty entry"); // RQ14

  property p_order_mid;
    disp_ops[1].valid |-> disp_ops[0].valid;
  endproperty
  a_order_mid: assert property (p_order_mid) else $error("lane 1 without lane 0"); // RQ2

  property p_room;
    cnt_q(disp_ops, idc_pkg::IDC_Q_GEN) <= {2'b00, $past(giq_room)}
      && cnt_q(disp_ops, idc_pkg::IDC_Q_VEC) <= {2'b00, $past(viq_room)}
      && cnt_q(disp_ops, idc_pkg::IDC_Q_FLT) <= {2'b00, $past(fiq_room)};
  endproperty
  a_room: assert property (p_room) else $error("issue queue overfilled"); // RQ1

  property p_ren_vf;
    {4'h0, disp_ops[0].ren_v} + {4'h0, disp_ops[1].ren_v} + {4'h0, disp_ops[2].ren_v} <= `IDC_LIM_RV
      && {4'h0, disp_ops[0].ren_f} + {4'h0, disp_ops[1].ren_f} + {4'h0, disp_ops[2].ren_f} <= `IDC_LIM_RF;
  endproperty
  a_ren_vf: assert property (p_ren_vf) else $error("vector or float rename limit"); // RQ6

  // ---------------------------------------------
  // Counter checks
  // ---------------------------------------------
  property p_cq_step;
    !$past(srst) |-> s_reg.cq_cnt == $past(s_reg.cq_cnt) + cnt_q(disp_ops, idc_pkg::IDC_Q_GEN)
      + cnt_q(disp_ops, idc_pkg::IDC_Q_VEC) + cnt_q(disp_ops, idc_pkg::IDC_Q_FLT) - {3'b000, $past(cq_retire)};
  endproperty
  a_cq_step: assert property (p_cq_step) else $error("completion count drifted"); // RQ9

  property p_g_step;
    !$past(srst) |-> s_reg.g_free == $past(s_reg.g_free) + {3'b000, $past(g_release)}
      - {3'b000, disp_ops[0].ren_g} - {3'b000, disp_ops[1].ren_g} - {3'b000, disp_ops[2].ren_g};
  endproperty
  a_g_step: assert property (p_g_step) else $error("general pool drifted"); // RQ7 RQ10

  property p_pool_floor;
    {3'b000, disp_ops[0].ren_g} + {3'b000, disp_ops[1].ren_g} + {3'b000, disp_ops[2].ren_g}
      <= $past(s_reg.g_free);
  endproperty
  a_pool_floor: assert property (p_pool_floor) else $error("renamed beyond free pool"); // RQ8

  property p_vf_step;
    !$past(srst) |-> s_reg.v_free == $past(s_reg.v_free) + {3'b000, $past(v_release)}
      - {4'h0, disp_ops[0].ren_v} - {4'h0, disp_ops[1].ren_v} - {4'h0, disp_ops[2].ren_v}
      && s_reg.f_free == $past(s_reg.f_free) + {3'b000, $past(f_release)}
      - {4'h0, disp_ops[0].ren_f} - {4'h0, disp_ops[1].ren_f} - {4'h0, disp_ops[2].ren_f};
  endproperty
  a_vf_step: assert property (p_vf_step) else $error("vector or float pool drifted"); // RQ10
endmodule
`default_nettype wire

// File: common/idc_params.svh
/*
  Constants of the instruction dispatch control block.
  Assumes it is included by bare name, after the package.
*/
// Operation
// RQ1 - An entry holds unless its issue queue has room, the completion queue has room, a branch is ready and renames are free.
// RQ2 - Entries dispatch in order, a younger one only when every older one also goes.
// RQ3 - At most three instructions leave per cycle.
// RQ4 - At most three go to the general, two to the vector and one to the float issue queue per cycle.
// RQ5 - At most one load or store dispatches per cycle.
// RQ6 - A group renames at most four general, three vector and two float registers.
// RQ7 - An update-form load or store takes one extra general rename.
// RQ8 - Sixteen general renames exist and a general target stalls when too few are free.
// RQ9 - The completion queue holds sixteen entries and dispatch stops when it is full.
// RQ10 - Renames return to the pool at write-back, which alone frees a rename stall.
// RQ11 - Multiple and string operations split into micro-operations, one per cycle.
// RQ12 - A load multiple yields one micro-operation per register up to 31, each on the next word.
// RQ13 - Non-memory instructions may join the final micro-operation in its cycle.
// RQ14 - A held entry stays unchanged and is retried every cycle without loss or reordering.
`ifndef IDC_PARAMS_SVH
`define IDC_PARAMS_SVH
`define IDC_CNT_W 5
`define IDC_LANES 3
`define IDC_LIM_TOT 5'h03
`define IDC_LIM_GIQ 5'h03
`define IDC_LIM_VIQ 5'h02
`define IDC_LIM_FIQ 5'h01
`define IDC_LIM_MEM 5'h01
`define IDC_LIM_RG 5'h04
`define IDC_LIM_RV 5'h03
`define IDC_LIM_RF 5'h02
`define IDC_CQ_DEPTH 16
`define IDC_GPR_REN 16
`define IDC_VR_REN 16
`define IDC_FPR_REN 16
`define IDC_LAST_REG 5'h1F
`endif

// File: common/idc_pkg.sv
/*
  Types of the instruction dispatch control block.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package idc_pkg;
  typedef enum logic [1:0] {
    IDC_Q_GEN = 2'b00,
    IDC_Q_VEC = 2'b01,
    IDC_Q_FLT = 2'b10,
    IDC_Q_BR = 2'b11
  } idc_queue_t;
  typedef struct packed {
    logic valid;
    idc_queue_t queue;
    logic mem;
    logic upd;
    logic multi;
    logic mstore;
    logic g_tgt;
    logic v_tgt;
    logic f_tgt;
    logic br_ready;
    logic [4:0] first_reg;
  } idc_entry_t;
  typedef struct packed {
    logic valid;
    idc_queue_t queue;
    logic mem;
    logic mop;
    logic [1:0] ren_g;
    logic ren_v;
    logic ren_f;
    logic [4:0] mreg;
    logic [4:0] mword;
  } idc_op_t;
  typedef struct packed {
    logic [4:0] cq_cnt;
    logic [4:0] g_free;
    logic [4:0] v_free;
    logic [4:0] f_free;
    logic mop_active;
    logic [4:0] mop_reg;
    logic [4:0] mop_word;
    idc_op_t [2:0] ops;
  } idc_state_t;
endpackage
`default_nettype wire

// File: verification/idc_iq_model.sv
/*
  Instruction queue model: bottom three entries seen by dispatch.
  Assumes the bench loads it whole or feeds one entry for refill.
*/
`timescale 1ns/1ns
`default_nettype none
module idc_iq_model (
  input wire logic ref_clk, // Core clock
  input wire logic load, // Replace all slots
  input wire idc_pkg::idc_entry_t [2:0] fill, // Slots to load
  input wire idc_pkg::idc_entry_t feed, // Refill for vacated slots
  input wire logic [1:0] iq_take, // Entries consumed
  output var idc_pkg::idc_entry_t [2:0] dispatch_entries // Bottom entries
);
  always_ff @(posedge ref_clk)
  begin
    if (load)
    begin
      dispatch_entries <= fill;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        // Held entries slide down untouched
        dispatch_entries[i] <= (i + iq_take < 3) ? dispatch_entries[i + iq_take] : feed;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/tb.sv
/*
  Self-checking bench of the dispatch stage.
  Assumes the instruction queue model beside it; no resource is over-released.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct packed {idc_pkg::idc_entry_t [2:0] e; logic [2:0] g; logic [1:0] t;} idc_row_t;
  localparam idc_pkg::idc_queue_t QG = idc_pkg::IDC_Q_GEN, QV = idc_pkg::IDC_Q_VEC;
  localparam idc_pkg::idc_queue_t QF = idc_pkg::IDC_Q_FLT, QB = idc_pkg::IDC_Q_BR;
  // Flags: mem, upd, multi, g, v, f
  localparam logic [5:0] ADD = 6'h04, LDU = 6'h34, ST = 6'h20, VA = 6'h02, FA = 6'h01;
  localparam logic [5:0] LFU = 6'h31, LVE = 6'h22, LMW = 6'h2C;
  logic ref_clk = 1'b0, srst = 1'b1, load = 1'b1;
  idc_pkg::idc_entry_t [2:0] fill = '0, dispatch_entries;
  idc_pkg::idc_entry_t feed = '0;
  logic [2:0] giq_room = 3'h3, viq_room = 3'h3, fiq_room = 3'h3;
  logic [1:0] cq_retire = 2'h0, g_release = 2'h0, v_release = 2'h0, f_release = 2'h0, iq_take;
  idc_pkg::idc_op_t [2:0] disp_ops;
  logic [4:0] g_free_cnt, cq_used;
  int errors = 0, checks_done = 0, cyc = 0;
  idc_row_t rows [11];
  always #25 ref_clk = ~ref_clk;
  idc_iq_model idc_iq_model_i (.ref_clk(ref_clk), .load(load), .fill(fill), .feed(feed),
    .iq_take(iq_take), .dispatch_entries(dispatch_entries));
  idc_dispatch idc_dispatch_i (.ref_clk(ref_clk), .srst(srst), .dispatch_entries(dispatch_entries),
    .giq_room(giq_room), .viq_room(viq_room), .fiq_room(fiq_room), .cq_retire(cq_retire),
    .g_release(g_release), .v_release(v_release), .f_release(f_release), .iq_take(iq_take),
    .disp_ops(disp_ops), .g_free_cnt(g_free_cnt), .cq_used(cq_used));
  function automatic idc_pkg::idc_entry_t ent(idc_pkg::idc_queue_t q, logic [5:0] fl);
    // Branches are never ready here
    return '{valid:1'b1, queue:q, mem:fl[5], upd:fl[4], multi:fl[3], mstore:1'b0, g_tgt:fl[2],
      v_tgt:fl[1], f_tgt:fl[0], br_ready:(q != QB), first_reg:5'h1D};
  endfunction
  function automatic idc_row_t row(idc_pkg::idc_entry_t a, b, c, logic [2:0] g, logic [1:0] t);
    idc_row_t r;
    r.e[0] = a;
    r.e[1] = b;
    r.e[2] = c;
    r.g = g;
    r.t = t;
    return r;
  endfunction
  task automatic cmp(input logic [4:0] got, input logic [4:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rst_load(input idc_pkg::idc_entry_t [2:0] e, input idc_pkg::idc_entry_t f,
    input logic [2:0] g);
    @(posedge ref_clk);
    srst <= 1'b1;
    load <= 1'b1;
    fill <= e;
    feed <= f;
    giq_room <= g;
    @(posedge ref_clk);
    srst <= 1'b0;
    load <= 1'b0;
    #5;
  endtask
  // Reads the live counter each cycle; a by-value copy would never change
  task automatic wait_until(input bit use_cq, input logic [4:0] exp);
    for (int n = 0; n < 40 && (use_cq ? cq_used : g_free_cnt) !== exp; n++)
    begin
      @(posedge ref_clk);
      #5;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      errors++;
      final_report();
    end
  end
  initial
  begin
    rows[0] = row(ent(QG, ADD), ent(QG, ADD), ent(QG, ADD), 3'h3, 2'h3);
    rows[1] = row(ent(QF, FA), ent(QF, FA), ent(QF, FA), 3'h3, 2'h1);
    rows[2] = row(ent(QV, VA), ent(QV, VA), ent(QV, VA), 3'h3, 2'h2);
    rows[3] = row(ent(QG, ST), ent(QG, ST), ent(QG, ADD), 3'h3, 2'h1);
    rows[4] = row(ent(QG, LDU), ent(QG, ADD), ent(QG, ADD), 3'h3, 2'h3);
    rows[5] = row(ent(QV, VA), ent(QV, VA), ent(QG, LVE), 3'h3, 2'h3);
    rows[6] = row(ent(QG, LFU), ent(QF, FA), ent(QG, ADD), 3'h3, 2'h3);
    rows[7] = row(ent(QB, 6'h00), ent(QG, ADD), ent(QG, ADD), 3'h3, 2'h0);
    rows[8] = row(ent(QG, ADD), ent(QB, 6'h00), ent(QG, ADD), 3'h3, 2'h1);
    rows[9] = row(ent(QG, ADD), ent(QG, ADD), ent(QG, ADD), 3'h1, 2'h1);
    rows[10] = row(ent(QG, ADD), ent(QG, ADD), ent(QG, ADD), 3'h0, 2'h0);
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    load <= 1'b0;
    #5;
    cmp(g_free_cnt, 5'h10);
    cmp(cq_used, 5'h00);
    cmp({4'h0, disp_ops === '0}, 5'h01);
    $display("test reset done");
    for (int r = 0; r < 11; r++)
    begin
      rst_load(rows[r].e, '0, rows[r].g);
      cmp({3'h0, iq_take}, {3'h0, rows[r].t});
    end
    $display("test groups done");
    // Eight update loads drain all sixteen general renames
    rst_load({3{ent(QG, LDU)}}, ent(QG, LDU), 3'h3);
    wait_until(1'b0, 5'h00);
    cmp(g_free_cnt, 5'h00);
    cmp(cq_used, 5'h08);
    cmp({3'h0, iq_take}, 5'h00);
    @(posedge ref_clk);
    g_release <= 2'h2;
    @(posedge ref_clk);
    g_release <= 2'h0;
    #5;
    cmp(g_free_cnt, 5'h02);
    cmp({3'h0, iq_take}, 5'h01);
    @(posedge ref_clk);
    #5;
    cmp({3'h0, disp_ops[0].ren_g}, 5'h02);
    $display("test renames done");
    rst_load({3{ent(QG, ST)}}, ent(QG, ST), 3'h3);
    wait_until(1'b1, 5'h10);
    cmp(cq_used, 5'h10);
    cmp({3'h0, iq_take}, 5'h00);
    @(posedge ref_clk);
    cq_retire <= 2'h1;
    @(posedge ref_clk);
    cq_retire <= 2'h0;
    #5;
    cmp(cq_used, 5'h0F);
    cmp({3'h0, iq_take}, 5'h01);
    $display("test completion done");
    rst_load({ent(QG, ADD), ent(QG, ADD), ent(QG, LMW)}, '0, 3'h3);
    for (int i = 0; i < 3; i++)
    begin
      cmp({3'h0, iq_take}, (i == 2) ? 5'h03 : 5'h00);
      @(posedge ref_clk);
      #5;
      cmp(disp_ops[0].mreg, 5'(5'h1D + i));
      cmp(disp_ops[0].mword, 5'(i));
      cmp({3'h0, disp_ops[0].mop, disp_ops[0].mem}, 5'h03);
      cmp({4'h0, disp_ops[1].valid}, 5'(i == 2));
    end
    cmp({4'h0, disp_ops[2].valid}, 5'h01);
    $display("test multiple done");
    final_report();
  end
endmodule
`default_nettype wire
